/* File: asfc_pkg.sv */
// asfc_pkg.sv: constants and types shared by the alert/status filter block
package asfc_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_STATUS = 8'h02;
  localparam logic [7:0] REG_MASK   = 8'h16;
  localparam logic [7:0] REG_HYST   = 8'h21;
  localparam logic [7:0] REG_MODE   = 8'hBF;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_BUSY   = 7;
  localparam int BIT_LOCAL_HIGH_ALARM  = 6;
  localparam int BIT_RSVD   = 5;
  localparam int BIT_REMOTE_HIGH_ALARM  = 4;
  localparam int BIT_REMOTE_LOW_ALARM   = 3;
  localparam int BIT_FAULT  = 2;
  localparam int BIT_REMOTE_CRITICAL_ALARM  = 1;
  localparam int BIT_TACH   = 0;
  localparam int MODE_CMP   = 0;
  localparam int MODE_FLT_L = 1;
  localparam int MODE_FLT_H = 2;

  // status bits that may raise the alert output
  localparam logic [7:0] ALERT_CAPABLE = 8'h5B;
  // mask register bits that are fixed at one
  localparam logic [7:0] MASK_FIXED1   = 8'hA4;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] MASK_RST  = 8'h00;
  localparam logic [6:0] HYST_RST  = 7'h0A;
  localparam logic [1:0] FILT_RST  = 2'h0;

  typedef enum logic [1:0] {
    ASFC_FILT_OFF,
    ASFC_FILT_L2,
    ASFC_FILT_ENH
  } asfc_filter_e;

  // temperatures and setpoints, whole degrees
  typedef struct packed {
    logic [7:0] localTemp;
    logic [7:0] remoteTemp;
    logic [7:0] localHighLimit;
    logic [7:0] remoteHighLimit;
    logic [7:0] remoteLowLimit;
    logic [7:0] critLimit;
  } asfc_temps_s;

  // host register access port
  typedef struct packed {
    logic [7:0] addr;
    logic       wrEn;
    logic       rdEn;
    logic [7:0] wrData;
  } asfc_regreq_s;

endpackage

/* File: asfc_alarm_latch.sv */
// asfc_alarm_latch.sv: one sticky alarm bit, cleared by a read
`timescale 1ns/100ps
module asfc_alarm_latch (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic cond,
  input  wire logic readClr,
  output logic      latched
);

  typedef struct packed {
    logic bit_;
  } asfc_latch_s;

  asfc_latch_s state;
  asfc_latch_s next_state;

  // a live condition always wins over the read clear, so no event is lost
  always_comb begin
    next_state.bit_ = cond | (state.bit_ & ~readClr);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign latched = state.bit_;

endmodule

/* File: asfc_alert_status_filter.sv */
// asfc_alert_status_filter.sv: alarm status, alert and critical outputs
// ----------------------------------------------------------------
// Functional notes
// - filter select 00 turns filtering off, 01 and 10 give level 2, 11 gives enhanced.
// - bits 5:3 of the filter and mode register always read zero.
// - with comparator mode clear the alert follows the latched alarm bits.
// - with comparator mode set the alert follows the live conditions only.
// - alarm bits latch until a status read and then clear only if the condition is gone.
// - status bit 7 shows the converter busy and never raises the alert.
// - local high alarm sets when local temperature is above its setpoint.
// - remote high alarm sets when remote temperature is above its setpoint.
// - remote low alarm sets when remote temperature is below its setpoint.
// - diode fault alarm sets on an open or shorted diode and drives no output.
// - remote critical alarm sets above the critical limit and drives alert and shutdown.
// - fan speed alarm sets when the tach count exceeds the tach limit.
// - status bit 5 always reads zero.
// - a set mask bit keeps its alarm off the alert but the status still reports it.
// - the shutdown output holds until remote temperature drops below limit minus hysteresis.
// ----------------------------------------------------------------
`timescale 1ns/100ps
module asfc_alert_status_filter #(
  parameter int TACH_W = 16
) (
  input  wire logic                    clk,
  input  wire logic                    reset,
  input  wire asfc_pkg::asfc_regreq_s  regReq,
  output logic [7:0]                   regRdData,
  input  wire asfc_pkg::asfc_temps_s   temps,
  input  wire logic [TACH_W-1:0]       tachCount,
  input  wire logic [TACH_W-1:0]       tachLimit,
  input  wire logic                    convBusy,
  input  wire logic                    diodeFault,
  output logic                         alertOut,
  output logic                         critShutdownOut,
  output asfc_pkg::asfc_filter_e       remoteFilterLevel
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]            mask;
    logic [6:0]            critHysteresis;
    logic [1:0]            remoteFilterSel;
    logic                  alertComparatorMode;
    logic [7:0]            rdData;
    logic                  alert;
    logic                  crit;
    asfc_pkg::asfc_filter_e filt;
  } asfc_state_s;

  asfc_state_s state;
  asfc_state_s next_state;

  logic [7:0] cond;
  logic [7:0] latched;
  logic [7:0] statusView;
  logic       statusRead;
  logic       critRelease;
  logic [8:0] remotePlusHyst;

  // ----------------------------------------------------------------
  // alarm conditions
  // ----------------------------------------------------------------
  // temperatures are compared as unsigned whole degrees
  always_comb begin
    cond                       = '0;
    cond[asfc_pkg::BIT_LOCAL_HIGH_ALARM]  =
      temps.localTemp > temps.localHighLimit;
    cond[asfc_pkg::BIT_REMOTE_HIGH_ALARM]  =
      temps.remoteTemp > temps.remoteHighLimit;
    cond[asfc_pkg::BIT_REMOTE_LOW_ALARM]   =
      temps.remoteTemp < temps.remoteLowLimit;
    cond[asfc_pkg::BIT_FAULT]  = diodeFault;
    cond[asfc_pkg::BIT_REMOTE_CRITICAL_ALARM]  =
      temps.remoteTemp > temps.critLimit;
    cond[asfc_pkg::BIT_TACH]   = tachCount > tachLimit;
  end

  assign statusRead = regReq.rdEn && (regReq.addr == asfc_pkg::REG_STATUS);

  // ----------------------------------------------------------------
  // sticky alarm bits
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : gAlarm
      if (gi == asfc_pkg::BIT_BUSY || gi == asfc_pkg::BIT_RSVD) begin : gNone
        assign latched[gi] = 1'b0;
      end else begin : gLatch
        asfc_alarm_latch uLatch (
          .clk     (clk),
          .reset   (reset),
          .cond    (cond[gi]),
          .readClr (statusRead),
          .latched (latched[gi])
        );
      end
    end
  endgenerate

  always_comb begin
    statusView                      = latched;
    statusView[asfc_pkg::BIT_BUSY]  = convBusy;
    statusView[asfc_pkg::BIT_RSVD]  = 1'b0;
  end

  // remote temperature plus hysteresis kept in nine bits so the sum never wraps
  assign remotePlusHyst = {1'b0, temps.remoteTemp} +
                          {2'b00, state.critHysteresis};
  assign critRelease    = remotePlusHyst < {1'b0, temps.critLimit};

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    // register writes; bits 7:3 of the mode register are not stored
    if (regReq.wrEn) begin
      unique case (regReq.addr)
        asfc_pkg::REG_MASK: begin
          next_state.mask = regReq.wrData & ~asfc_pkg::MASK_FIXED1;
        end
        asfc_pkg::REG_HYST: begin
          next_state.critHysteresis = regReq.wrData[6:0];
        end
        asfc_pkg::REG_MODE: begin
          next_state.remoteFilterSel =
            regReq.wrData[asfc_pkg::MODE_FLT_H:asfc_pkg::MODE_FLT_L];
          next_state.alertComparatorMode =
            regReq.wrData[asfc_pkg::MODE_CMP];
        end
        default: begin
        end
      endcase
    end
    // read data
    next_state.rdData = 8'h00;
    if (regReq.rdEn) begin
      unique case (regReq.addr)
        asfc_pkg::REG_STATUS: begin
          next_state.rdData = statusView;
        end
        asfc_pkg::REG_MASK: begin
          next_state.rdData = state.mask | asfc_pkg::MASK_FIXED1;
        end
        asfc_pkg::REG_HYST: begin
          next_state.rdData = {1'b0, state.critHysteresis};
        end
        asfc_pkg::REG_MODE: begin
          next_state.rdData = {5'b0_0000, state.remoteFilterSel,
                               state.alertComparatorMode};
        end
        default: begin
          next_state.rdData = 8'h00;
        end
      endcase
    end
    // comparator mode follows live conditions, otherwise the latches
    if (state.alertComparatorMode) begin
      next_state.alert = |(cond & asfc_pkg::ALERT_CAPABLE &
                            ~state.mask);
    end else begin
      next_state.alert = |(latched & asfc_pkg::ALERT_CAPABLE &
                            ~state.mask);
    end
    // critical output ignores the mask and has its own hysteresis
    if (cond[asfc_pkg::BIT_REMOTE_CRITICAL_ALARM]) begin
      next_state.crit = 1'b1;
    end else if (critRelease) begin
      next_state.crit = 1'b0;
    end
    unique case (state.remoteFilterSel)
      2'b00: next_state.filt = asfc_pkg::ASFC_FILT_OFF;
      2'b01: next_state.filt = asfc_pkg::ASFC_FILT_L2;
      2'b10: next_state.filt = asfc_pkg::ASFC_FILT_L2;
      2'b11: next_state.filt = asfc_pkg::ASFC_FILT_ENH;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state.mask                <= asfc_pkg::MASK_RST;
      state.critHysteresis      <= asfc_pkg::HYST_RST;
      state.remoteFilterSel     <= asfc_pkg::FILT_RST;
      state.alertComparatorMode <= 1'b0;
      state.rdData              <= 8'h00;
      state.alert               <= 1'b0;
      state.crit                <= 1'b0;
      state.filt                <= asfc_pkg::ASFC_FILT_OFF;
    end else begin
      state <= next_state;
    end
  end

  assign regRdData         = state.rdData;
  assign alertOut          = state.alert;
  assign critShutdownOut   = state.crit;
  assign remoteFilterLevel = state.filt;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_filter_enh_map: assert property (
    state.remoteFilterSel == 2'b11 |=>
      remoteFilterLevel == asfc_pkg::ASFC_FILT_ENH)
    else $error("filter code 11 did not give enhanced level");
  a_mode_mid_zero: assert property (
    regReq.rdEn && regReq.addr == asfc_pkg::REG_MODE |=>
      regRdData[5:3] == 3'b000)
    else $error("mode register bits 5:3 not zero");
  a_latch_alert_on: assert property (
    !state.alertComparatorMode && latched[asfc_pkg::BIT_LOCAL_HIGH_ALARM] &&
    !state.mask[asfc_pkg::BIT_LOCAL_HIGH_ALARM] |=> alertOut)
    else $error("latched unmasked alarm did not raise alert");
  a_cmp_alert_off: assert property (
    state.alertComparatorMode &&
    ((cond & asfc_pkg::ALERT_CAPABLE & ~state.mask) == 8'h00) |=> !alertOut)
    else $error("comparator alert stayed without condition");
  a_status_read_clr: assert property (
    statusRead && !cond[asfc_pkg::BIT_REMOTE_HIGH_ALARM] |=>
      !latched[asfc_pkg::BIT_REMOTE_HIGH_ALARM])
    else $error("alarm not cleared by read");
  a_alarm_sticky: assert property (
    cond[asfc_pkg::BIT_REMOTE_LOW_ALARM] ##1 !statusRead [*2] |=>
      latched[asfc_pkg::BIT_REMOTE_LOW_ALARM])
    else $error("alarm lost before read");
  a_status_rsvd_zero: assert property (
    statusRead |=> regRdData[asfc_pkg::BIT_RSVD] == 1'b0)
    else $error("status bit 5 not zero");
  a_busy_no_alert: assert property (
    (latched & asfc_pkg::ALERT_CAPABLE) == 8'h00 &&
    !state.alertComparatorMode |=> !alertOut)
    else $error("busy or fault raised alert");
  a_crit_sets: assert property (
    cond[asfc_pkg::BIT_REMOTE_CRITICAL_ALARM] |=> critShutdownOut)
    else $error("shutdown not set above critical");
  a_crit_holds: assert property (
    critShutdownOut && !critRelease |=> critShutdownOut)
    else $error("shutdown released inside hysteresis");
  a_mask_blocks: assert property (
    !state.alertComparatorMode &&
    (state.mask & asfc_pkg::ALERT_CAPABLE) == asfc_pkg::ALERT_CAPABLE
    |=> !alertOut)
    else $error("masked alarm raised alert");

  c_crit_cycle: cover property (
    critShutdownOut ##[1:1000] !critShutdownOut);
  c_read_clear: cover property (
    latched[asfc_pkg::BIT_TACH] && statusRead ##1
      !latched[asfc_pkg::BIT_TACH]);
  c_cmp_alert: cover property (
    state.alertComparatorMode && alertOut ##1 !alertOut);

endmodule

/* File: asfc_host_model.sv */
// asfc_host_model.sv: register host that drives the block's access port
`timescale 1ns/100ps
module asfc_host_model (
  input  wire logic              clk,
  output asfc_pkg::asfc_regreq_s regReq,
  input  wire logic [7:0]        regRdData
);
  initial begin
    regReq = '0;
  end
  // ----------------------------------------------------------------
  // one strobe per access, dropped after the edge that takes it
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    regReq.addr = a;
    // mode bits 7:6 are never written as one
    regReq.wrData = (a == asfc_pkg::REG_MODE) ? (d & 8'h3F) : d;
    regReq.wrEn = 1'b1;
    @(posedge clk);
    #1;
    regReq.wrEn = 1'b0;
  endtask
  // read data is registered, so it is taken one cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    regReq.addr = a;
    regReq.rdEn = 1'b1;
    @(posedge clk);
    #1;
    regReq.rdEn = 1'b0;
    d = regRdData;
  endtask
endmodule

/* File: tb.sv */
// tb.sv: self-checking bench for the alert and status block
`timescale 1ns/100ps
module tb;
  logic                   clk;
  logic                   reset;
  asfc_pkg::asfc_regreq_s regReq;
  logic [7:0]             regRdData;
  asfc_pkg::asfc_temps_s  temps;
  logic [15:0]            tachCount;
  logic [15:0]            tachLimit;
  logic                   convBusy;
  logic                   diodeFault;
  logic                   alertOut;
  logic                   critShutdownOut;
  asfc_pkg::asfc_filter_e remoteFilterLevel;
  logic [7:0]             rdv;
  int                     badCount;
  int                     comparisons;

  asfc_alert_status_filter #(.TACH_W(16)) asfc_alert_status_filter_i (
    .clk(clk), .reset(reset), .regReq(regReq), .regRdData(regRdData),
    .temps(temps), .tachCount(tachCount), .tachLimit(tachLimit),
    .convBusy(convBusy), .diodeFault(diodeFault), .alertOut(alertOut),
    .critShutdownOut(critShutdownOut),
    .remoteFilterLevel(remoteFilterLevel)
  );
  asfc_host_model asfc_host_model_i (
    .clk(clk), .regReq(regReq), .regRdData(regRdData)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    asfc_host_model_i.rd(a, rdv);
  endtask
  task automatic cmp8(input logic [7:0] g, input logic [7:0] e,
                      input string m);
    comparisons++;
    if (g !== e) begin
      badCount++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask
  task automatic cmp1(input logic g, input logic e, input string m);
    cmp8({7'h00, g}, {7'h00, e}, m);
  endtask
  // every condition sits well inside its setpoints
  task automatic calm();
    temps = {8'h28, 8'h32, 8'h3C, 8'h46, 8'h14, 8'h64};
    tachCount = 16'h0064;
    tachLimit = 16'h00C8;
    diodeFault = 1'b0;
  endtask
  task automatic trip(input int b);
    case (b)
      6: temps.localTemp = 8'h3D;
      4: temps.remoteTemp = 8'h47;
      3: temps.remoteTemp = 8'h13;
      2: diodeFault = 1'b1;
      // lift the high setpoint so only the critical compare trips
      1: {temps.remoteHighLimit, temps.remoteTemp} = {8'hC8, 8'h65};
      default: tachCount = 16'h00C9;
    endcase
  endtask
  task automatic flush();
    calm();
    step(2);
    rd(asfc_pkg::REG_STATUS);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd(asfc_pkg::REG_MASK);
    cmp8(rdv, 8'hA4, "mask reset");
    rd(asfc_pkg::REG_HYST);
    cmp8(rdv, 8'h0A, "hyst reset");
    rd(asfc_pkg::REG_MODE);
    cmp8(rdv, 8'h00, "mode reset");
    rd(asfc_pkg::REG_STATUS);
    cmp8(rdv, 8'h00, "status reset");
    rd(8'h55);
    cmp8(rdv, 8'h00, "unmapped read");
    $display("test reset done");
  endtask
  task automatic t_mode();
    asfc_host_model_i.wr(asfc_pkg::REG_MODE, 8'hFF);
    rd(asfc_pkg::REG_MODE);
    cmp8(rdv, 8'h07, "mode readback");
    for (int c = 0; c < 4; c++) begin
      asfc_host_model_i.wr(asfc_pkg::REG_MODE, 8'(c << 1));
      step(2);
      cmp8({6'h00, remoteFilterLevel}, (c == 0) ? asfc_pkg::ASFC_FILT_OFF :
           (c == 3) ? asfc_pkg::ASFC_FILT_ENH : asfc_pkg::ASFC_FILT_L2,
           "filter level");
    end
    $display("test mode done");
  endtask
  task automatic t_alarms();
    int bits[6] = '{6, 4, 3, 2, 1, 0};
    logic [7:0] e;
    // local high, remote high, remote low and tach compares exactly at their setpoints stay quiet
    {temps.localTemp, temps.remoteTemp, tachCount} = {8'h3C, 8'h46, 16'h00C8};
    step(3);
    rd(asfc_pkg::REG_STATUS);
    cmp8(rdv, 8'h00, "at high setpoints");
    temps.remoteTemp = 8'h14;
    step(3);
    rd(asfc_pkg::REG_STATUS);
    cmp8(rdv, 8'h00, "at low setpoint");
    foreach (bits[i]) begin
      e = 8'h01 << bits[i];
      calm();
      trip(bits[i]);
      step(3);
      cmp1(alertOut, bits[i] != 2, "alert on trip");
      cmp1(critShutdownOut, bits[i] == 1, "shutdown");
      rd(asfc_pkg::REG_STATUS);
      cmp8(rdv, e, "live status");
      calm();
      step(3);
      cmp1(alertOut, bits[i] != 2, "alert held");
      rd(asfc_pkg::REG_STATUS);
      cmp8(rdv, e, "latched status");
      step(2);
      cmp1(alertOut, 1'b0, "alert after clear");
      rd(asfc_pkg::REG_STATUS);
      cmp8(rdv, 8'h00, "cleared status");
    end
    $display("test alarms done");
  endtask
  task automatic t_hyst();
    asfc_host_model_i.wr(asfc_pkg::REG_HYST, 8'h85);
    rd(asfc_pkg::REG_HYST);
    cmp8(rdv, 8'h05, "hyst readback");
    // limit 100 less hysteresis 5: 95 holds, 94 releases
    trip(1);
    step(2);
    cmp1(critShutdownOut, 1'b1, "shutdown set");
    temps.remoteTemp = 8'h5F;
    step(2);
    cmp1(critShutdownOut, 1'b1, "shutdown holds");
    temps.remoteTemp = 8'h5E;
    step(2);
    cmp1(critShutdownOut, 1'b0, "shutdown drops");
    asfc_host_model_i.wr(asfc_pkg::REG_HYST, 8'h0A);
    flush();
    $display("test hyst done");
  endtask
  task automatic t_mask();
    asfc_host_model_i.wr(asfc_pkg::REG_MASK, 8'h10);
    rd(asfc_pkg::REG_MASK);
    cmp8(rdv, 8'hB4, "mask readback");
    trip(4);
    step(3);
    cmp1(alertOut, 1'b0, "masked alert");
    rd(asfc_pkg::REG_STATUS);
    cmp8(rdv, 8'h10, "masked status");
    asfc_host_model_i.wr(asfc_pkg::REG_MASK, 8'h00);
    step(2);
    cmp1(alertOut, 1'b1, "unmasked alert");
    flush();
    $display("test mask done");
  endtask
  task automatic t_cmp();
    asfc_host_model_i.wr(asfc_pkg::REG_MODE, 8'h01);
    trip(6);
    step(2);
    cmp1(alertOut, 1'b1, "comparator on");
    calm();
    step(2);
    cmp1(alertOut, 1'b0, "comparator off");
    rd(asfc_pkg::REG_STATUS);
    cmp8(rdv, 8'h40, "comparator latch");
    asfc_host_model_i.wr(asfc_pkg::REG_MODE, 8'h00);
    flush();
    $display("test comparator done");
  endtask
  task automatic t_busy();
    convBusy = 1'b1;
    step(2);
    rd(asfc_pkg::REG_STATUS);
    cmp8(rdv, 8'h80, "busy status");
    cmp1(alertOut, 1'b0, "busy alert");
    convBusy = 1'b0;
    rd(asfc_pkg::REG_STATUS);
    cmp8(rdv, 8'h00, "idle status");
    $display("test busy done");
  endtask

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, badCount);
    if (badCount == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // a hang is cut short at 200000 ns, far beyond the length of a normal run
  initial begin
    #200000;
    badCount++;
    $display("unexpected at %0t: run limit", $time);
    end_of_test();
  end
  initial begin
    reset = 1'b1;
    convBusy = 1'b0;
    calm();
    repeat (6) @(posedge clk);
    #1;
    reset = 1'b0;
    step(1);
    t_reset();
    t_mode();
    t_alarms();
    t_hyst();
    t_mask();
    t_cmp();
    t_busy();
    end_of_test();
  end
endmodule
